// ### core/pic_top.sv
// pic_top: interrupt request collection, per-source priority enables,
// global enable and request forwarding to the processor core.
// assumes: source and core strobes are one-cycle pulses on sys_clk;
// port pins are asynchronous; register port answers reads one cycle later.
//
// Behaviour
// - selectable pins request on chosen edge
// - other pins request on every edge
// - watchdog and oscillator traps bypass registers
// - a source request sets its bit
// - global enable on forwards enabled pending request
// - request register zero layout, resets zero
// - enable low register, reserved bits read zero
// - high/low enable pair encodes priority level
// - global enable set by on/return/write one
// - cleared by off/ack/reset/write zero
// - control bits six to zero read zero
module pic_top (
   input  wire logic                      sys_clk,
   input  wire logic                      reset,
   input  wire logic                      clk_en,
   input  wire logic [pic_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [pic_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic [pic_pkg::DATA_W-1:0]      reg_rdata,
   input  pic_pkg::pic_src_s              src_evt,
   input  wire logic [pic_pkg::PIN_N-1:0]  port_pin,
   input  pic_pkg::pic_bypass_s           bypass_evt,
   input  wire logic                      bypass_ack,
   input  pic_pkg::pic_core_op_s          core_op,
   output pic_pkg::pic_grant_s            core_req,
   output logic                           bypass_req,
   output logic                           irq_status
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]                 req0_q, req0_d;
   logic [7:0]                 req0_enh_q, req0_enh_d;
   logic [7:0]                 req0_enl_q, req0_enl_d;
   logic [pic_pkg::REQ1_W-1:0] req1_q, req1_d;
   logic [pic_pkg::REQ1_W-1:0] req1_enh_q, req1_enh_d;
   logic [pic_pkg::REQ1_W-1:0] req1_enl_q, req1_enl_d;
   logic [pic_pkg::SEL_N-1:0]  edge_sel_q, edge_sel_d;
   logic [pic_pkg::EVT_W-1:0]  evt_stat_q, evt_stat_d;
   logic [pic_pkg::EVT_W-1:0]  evt_mask_q, evt_mask_d;
   logic                       gie_q, gie_d;
   logic                       bypass_q, bypass_d;
   logic                       irq_q, irq_d;
   pic_pkg::pic_grant_s        grant_q, grant_d;
   logic [7:0]                 rdata_q, rdata_d;

   logic [pic_pkg::PIN_N-1:0]  pin_meta_q;
   logic [pic_pkg::PIN_N-1:0]  pin_sync_q;
   logic [pic_pkg::PIN_N-1:0]  pin_prev_q;
   logic [pic_pkg::PIN_N-1:0]  pin_rise;
   logic [pic_pkg::PIN_N-1:0]  pin_fall;
   logic [pic_pkg::REQ1_W-1:0] pin_req;
   logic [7:0]                 src_set0;

   logic [pic_pkg::NUM_SRC-1:0]      pend_all;
   logic [pic_pkg::NUM_SRC-1:0][1:0] lvl_all;
   pic_pkg::pic_grant_s              best;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      return a == off;
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // prev starts at zero, so a pin already high at reset release shows
   // one rising edge; software should clear request one after setup
   generate
      for (genvar p = 0; p < pic_pkg::PIN_N; p++) begin : g_pin
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               pin_meta_q[p] <= 1'b0;
               pin_sync_q[p] <= 1'b0;
               pin_prev_q[p] <= 1'b0;
            end else if (clk_en) begin
               pin_meta_q[p] <= port_pin[p];
               pin_sync_q[p] <= pin_meta_q[p];
               pin_prev_q[p] <= pin_sync_q[p];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // edge detection
   // ----------------------------------------------------------------
   always_comb begin
      pin_rise = pin_sync_q & ~pin_prev_q;
      pin_fall = ~pin_sync_q & pin_prev_q;
      for (int i = 0; i < pic_pkg::PIN_N; i++) begin
         if (i < pic_pkg::SEL_N) begin
            pin_req[i] = edge_sel_q[i] ? pin_fall[i] : pin_rise[i];
         end else begin
            pin_req[i] = pin_rise[i] | pin_fall[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // source request vector, register zero layout
   // ----------------------------------------------------------------
   always_comb begin
      src_set0                         = 8'h00;
      src_set0[pic_pkg::BIT_TIMER_ONE]  = src_evt.timer_one;
      src_set0[pic_pkg::BIT_TIMER_ZERO] = src_evt.timer_zero;
      src_set0[pic_pkg::BIT_SERIAL_RX]  = src_evt.serial_rx;
      src_set0[pic_pkg::BIT_SERIAL_TX]  = src_evt.serial_tx;
      src_set0[pic_pkg::BIT_CONVERTER]  = src_evt.converter;
   end

   // ----------------------------------------------------------------
   // register next state
   // ----------------------------------------------------------------
   always_comb begin
      req0_d     = req0_q;
      req0_enh_d = req0_enh_q;
      req0_enl_d = req0_enl_q;
      req1_d     = req1_q;
      req1_enh_d = req1_enh_q;
      req1_enl_d = req1_enl_q;
      edge_sel_d = edge_sel_q;
      evt_stat_d = evt_stat_q;
      evt_mask_d = evt_mask_q;
      gie_d      = gie_q;
      if (reg_wr) begin
         // reserved bits are dropped on write so they always hold zero
         if (hit(reg_addr, pic_pkg::ADDR_REQ0)) begin
            req0_d = reg_wdata & pic_pkg::REQ0_MASK;
         end
         if (hit(reg_addr, pic_pkg::ADDR_REQ0_ENH)) begin
            req0_enh_d = reg_wdata & pic_pkg::REQ0_MASK;
         end
         if (hit(reg_addr, pic_pkg::ADDR_REQ0_ENL)) begin
            req0_enl_d = reg_wdata & pic_pkg::REQ0_MASK;
         end
         if (hit(reg_addr, pic_pkg::ADDR_REQ1)) begin
            req1_d = reg_wdata[pic_pkg::REQ1_W-1:0];
         end
         if (hit(reg_addr, pic_pkg::ADDR_REQ1_ENH)) begin
            req1_enh_d = reg_wdata[pic_pkg::REQ1_W-1:0];
         end
         if (hit(reg_addr, pic_pkg::ADDR_REQ1_ENL)) begin
            req1_enl_d = reg_wdata[pic_pkg::REQ1_W-1:0];
         end
         if (hit(reg_addr, pic_pkg::ADDR_EDGE_SEL)) begin
            edge_sel_d = reg_wdata[pic_pkg::SEL_N-1:0];
         end
         if (hit(reg_addr, pic_pkg::ADDR_EVT_STAT)) begin
            evt_stat_d = evt_stat_q & ~reg_wdata[pic_pkg::EVT_W-1:0];
         end
         if (hit(reg_addr, pic_pkg::ADDR_EVT_MASK)) begin
            evt_mask_d = reg_wdata[pic_pkg::EVT_W-1:0];
         end
         if (hit(reg_addr, pic_pkg::ADDR_CTL) && !reg_wdata[pic_pkg::BIT_GIE]) begin
            gie_d = 1'b0;
         end
      end
      // acknowledge retires the granted request and closes the gate
      if (core_op.ack) begin
         gie_d = 1'b0;
         if (grant_q.valid) begin
            if (grant_q.index < pic_pkg::REQ1_BASE[pic_pkg::IDX_W-1:0]) begin
               req0_d[grant_q.index[2:0]] = 1'b0;
            end else begin
               req1_d[grant_q.index[1:0]] = 1'b0;
            end
         end
      end
      if (core_op.off) begin
         gie_d = 1'b0;
      end
      // sets come last so a new event or enable beats a same-cycle clear
      if (core_op.on || core_op.return_from_interrupt_op) begin
         gie_d = 1'b1;
      end
      if (reg_wr && hit(reg_addr, pic_pkg::ADDR_CTL) && reg_wdata[pic_pkg::BIT_GIE]) begin
         gie_d = 1'b1;
      end
      req0_d = req0_d | src_set0;
      req1_d = req1_d | pin_req;
      if (|src_set0) begin
         evt_stat_d[pic_pkg::EVT_REQ0] = 1'b1;
      end
      if (|pin_req) begin
         evt_stat_d[pic_pkg::EVT_REQ1] = 1'b1;
      end
      if (core_op.ack && !grant_q.valid) begin
         evt_stat_d[pic_pkg::EVT_STRAY_ACK] = 1'b1;
      end
      irq_d = |(evt_stat_d & evt_mask_d);
   end

   // ----------------------------------------------------------------
   // forwarding to the core
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < pic_pkg::NUM_SRC; i++) begin
         if (i < pic_pkg::REQ1_BASE) begin
            pend_all[i] = req0_q[i];
            lvl_all[i]  = {req0_enh_q[i], req0_enl_q[i]};
         end else if (i < pic_pkg::REQ1_BASE + pic_pkg::REQ1_W) begin
            pend_all[i] = req1_q[i - pic_pkg::REQ1_BASE];
            lvl_all[i]  = {req1_enh_q[i - pic_pkg::REQ1_BASE], req1_enl_q[i - pic_pkg::REQ1_BASE]};
         end else begin
            pend_all[i] = 1'b0;
            lvl_all[i]  = 2'h0;
         end
      end
   end

   pic_prio u_prio (
      .pending (pend_all),
      .level   (lvl_all),
      .best    (best)
   );

   always_comb begin
      // with the gate closed nothing is offered; software polls instead
      grant_d = '0;
      if (gie_d && best.valid && !core_op.ack) begin
         grant_d = best;
      end
      // traps never pass the request, enable or priority registers
      bypass_d = bypass_q;
      if (bypass_ack) begin
         bypass_d = 1'b0;
      end
      if (bypass_evt.wdt || bypass_evt.osc_fail || bypass_evt.wdt_osc_fail) begin
         bypass_d = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   always_comb begin
      rdata_d = 8'h00;
      if (reg_rd) begin
         if (hit(reg_addr, pic_pkg::ADDR_REQ0)) begin
            rdata_d = req0_q;
         end else if (hit(reg_addr, pic_pkg::ADDR_REQ0_ENH)) begin
            rdata_d = req0_enh_q;
         end else if (hit(reg_addr, pic_pkg::ADDR_REQ0_ENL)) begin
            rdata_d = req0_enl_q & pic_pkg::REQ0_MASK;
         end else if (hit(reg_addr, pic_pkg::ADDR_REQ1)) begin
            rdata_d = {4'h0, req1_q};
         end else if (hit(reg_addr, pic_pkg::ADDR_REQ1_ENH)) begin
            rdata_d = {4'h0, req1_enh_q};
         end else if (hit(reg_addr, pic_pkg::ADDR_REQ1_ENL)) begin
            rdata_d = {4'h0, req1_enl_q};
         end else if (hit(reg_addr, pic_pkg::ADDR_EDGE_SEL)) begin
            rdata_d = {6'h00, edge_sel_q};
         end else if (hit(reg_addr, pic_pkg::ADDR_EVT_STAT)) begin
            rdata_d = {5'h00, evt_stat_q};
         end else if (hit(reg_addr, pic_pkg::ADDR_EVT_MASK)) begin
            rdata_d = {5'h00, evt_mask_q};
         end else if (hit(reg_addr, pic_pkg::ADDR_CTL)) begin
            rdata_d = {gie_q, 7'h00};
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         req0_q     <= pic_pkg::RST_BYTE;
         req0_enh_q <= pic_pkg::RST_BYTE;
         req0_enl_q <= pic_pkg::RST_BYTE;
         req1_q     <= pic_pkg::RST_REQ1;
         req1_enh_q <= pic_pkg::RST_REQ1;
         req1_enl_q <= pic_pkg::RST_REQ1;
         edge_sel_q <= pic_pkg::RST_SEL;
         evt_stat_q <= pic_pkg::RST_EVT;
         evt_mask_q <= pic_pkg::RST_EVT;
         gie_q      <= 1'b0;
         bypass_q   <= 1'b0;
         irq_q      <= 1'b0;
         grant_q    <= '0;
         rdata_q    <= pic_pkg::RST_BYTE;
      end else if (clk_en) begin
         req0_q     <= req0_d;
         req0_enh_q <= req0_enh_d;
         req0_enl_q <= req0_enl_d;
         req1_q     <= req1_d;
         req1_enh_q <= req1_enh_d;
         req1_enl_q <= req1_enl_d;
         edge_sel_q <= edge_sel_d;
         evt_stat_q <= evt_stat_d;
         evt_mask_q <= evt_mask_d;
         gie_q      <= gie_d;
         bypass_q   <= bypass_d;
         irq_q      <= irq_d;
         grant_q    <= grant_d;
         rdata_q    <= rdata_d;
      end
   end

   assign reg_rdata  = rdata_q;
   assign core_req   = grant_q;
   assign bypass_req = bypass_q;
   assign irq_status = irq_q;

endmodule // pic_top

// ### pkg/pic_pkg.sv
// pic_pkg: register map, field layout, reset values and carrier types
// of the prioritized interrupt controller.
// assumes: one system clock domain; a 12-bit register address space.
package pic_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W  = 12;
   localparam int unsigned DATA_W  = 8;
   localparam int unsigned REQ1_W  = 4;
   localparam int unsigned PIN_N   = 4;
   localparam int unsigned SEL_N   = 2;
   localparam int unsigned NUM_SRC = 16;
   localparam int unsigned IDX_W   = 4;
   localparam int unsigned EVT_W   = 3;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_REQ0     = 12'h0fc0;
   localparam logic [11:0] ADDR_REQ0_ENH = 12'h0fc1;
   localparam logic [11:0] ADDR_REQ0_ENL = 12'h0fc2;
   localparam logic [11:0] ADDR_REQ1     = 12'h0fc3;
   localparam logic [11:0] ADDR_REQ1_ENH = 12'h0fc4;
   localparam logic [11:0] ADDR_REQ1_ENL = 12'h0fc5;
   localparam logic [11:0] ADDR_EDGE_SEL = 12'h0fc6;
   localparam logic [11:0] ADDR_EVT_STAT = 12'h0fc7;
   localparam logic [11:0] ADDR_EVT_MASK = 12'h0fc8;
   localparam logic [11:0] ADDR_CTL      = 12'h0fcf;

   // ----------------------------------------------------------------
   // field positions and masks
   // ----------------------------------------------------------------
   localparam int unsigned BIT_TIMER_ONE = 6;
   localparam int unsigned BIT_TIMER_ZERO = 5;
   localparam int unsigned BIT_SERIAL_RX = 4;
   localparam int unsigned BIT_SERIAL_TX = 3;
   localparam int unsigned BIT_CONVERTER = 0;
   localparam int unsigned BIT_GIE       = 7;
   localparam int unsigned REQ1_BASE     = 8;
   localparam logic [7:0]  REQ0_MASK     = 8'h79;
   localparam int unsigned EVT_REQ0      = 0;
   localparam int unsigned EVT_REQ1      = 1;
   localparam int unsigned EVT_STRAY_ACK = 2;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]        RST_BYTE = 8'h00;
   localparam logic [REQ1_W-1:0] RST_REQ1 = 4'h0;
   localparam logic [SEL_N-1:0]  RST_SEL  = 2'h0;
   localparam logic [EVT_W-1:0]  RST_EVT  = 3'h0;
   localparam logic [PIN_N-1:0]  RST_PIN  = 4'h0;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic             valid;
      logic [IDX_W-1:0] index;
      logic [1:0]       level;
   } pic_grant_s;

   typedef struct packed {
      logic on;
      logic off;
      logic return_from_interrupt_op;
      logic ack;
   } pic_core_op_s;

   typedef struct packed {
      logic timer_one;
      logic timer_zero;
      logic serial_rx;
      logic serial_tx;
      logic converter;
   } pic_src_s;

   typedef struct packed {
      logic wdt;
      logic osc_fail;
      logic wdt_osc_fail;
   } pic_bypass_s;

endpackage

// ### core/pic_prio.sv
// pic_prio: combinational priority selection over all governed sources.
// assumes: pending and level vectors come from registers of the same clock.
module pic_prio (
   input  wire logic [pic_pkg::NUM_SRC-1:0]      pending,
   input  wire logic [pic_pkg::NUM_SRC-1:0][1:0] level,
   output pic_pkg::pic_grant_s                   best
);

   // ----------------------------------------------------------------
   // selection
   // ----------------------------------------------------------------
   // strictly-greater compare: on equal level the lowest index keeps it
   always_comb begin
      best = '0;
      for (int i = 0; i < pic_pkg::NUM_SRC; i++) begin
         if (pending[i] && (level[i] != 2'h0) && (!best.valid || (level[i] > best.level))) begin
            best.valid = 1'b1;
            best.index = i[pic_pkg::IDX_W-1:0];
            best.level = level[i];
         end
      end
   end

endmodule // pic_prio

// ### tb/pic_assertions.sv
// pic_assertions: timing checks on the ports of pic_top.
// assumes: bound into pic_top; clk_en held high by the bench.
module pic_assertions (
   input wire logic                       sys_clk,
   input wire logic                       reset,
   input wire logic                       clk_en,
   input wire logic [pic_pkg::ADDR_W-1:0] reg_addr,
   input wire logic                       reg_wr,
   input wire logic                       reg_rd,
   input wire logic [pic_pkg::DATA_W-1:0] reg_rdata,
   input pic_pkg::pic_bypass_s            bypass_evt,
   input wire logic                       bypass_ack,
   input pic_pkg::pic_core_op_s           core_op,
   input pic_pkg::pic_grant_s             core_req,
   input wire logic                       bypass_req
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   rdata_idle_a: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read answer");
   ctl_read_a: assert property ($past(clk_en && reg_rd && reg_addr == pic_pkg::ADDR_CTL)
      |-> reg_rdata[6:0] == 7'h00) else $error("control low bits not zero");
   enl_read_a: assert property ($past(clk_en && reg_rd && reg_addr == pic_pkg::ADDR_REQ0_ENL)
      |-> (reg_rdata & 8'h86) == 8'h00) else $error("enable low reserved bits not zero");
   grant_level_a: assert property (core_req.valid |-> core_req.level != 2'h0)
      else $error("disabled level offered");
   grant_index_a: assert property (core_req.valid |-> core_req.index inside {4'h0, [4'h3:4'h6], [4'h8:4'hb]})
      else $error("grant index not a governed source");
   // set beats clear, so only a lone clear must drop the offer
   ack_drop_a: assert property (clk_en && core_op.ack && !core_op.on && !core_op.return_from_interrupt_op && !reg_wr
      |=> !core_req.valid) else $error("offer stays after ack");
   off_drop_a: assert property (clk_en && core_op.off && !core_op.on && !core_op.return_from_interrupt_op && !reg_wr
      |=> !core_req.valid) else $error("offer stays after off");
   bypass_set_a: assert property (clk_en && (|bypass_evt) |=> bypass_req)
      else $error("bypass request missing");
   bypass_hold_a: assert property (clk_en && bypass_req && !bypass_ack |=> bypass_req)
      else $error("bypass request dropped without ack");
endmodule // pic_assertions

bind pic_top pic_assertions pic_assertions_inst (.sys_clk, .reset, .clk_en, .reg_addr, .reg_wr, .reg_rd,
   .reg_rdata, .bypass_evt, .bypass_ack, .core_op, .core_req, .bypass_req);

// ### tb/pic_core_model.sv
// pic_core_model: processor side that services offered requests.
// assumes: ack is one cycle; wait_n sets how long it dawdles first.
module pic_core_model (
   input wire logic           sys_clk,
   input wire logic           reset,
   input wire logic           ack_en,
   input wire logic [3:0]     wait_n,
   input pic_pkg::pic_grant_s core_req,
   output logic               ack,
   output pic_pkg::pic_grant_s served,
   output logic [7:0]         served_cnt
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_q;

   always @(posedge sys_clk) begin
      if (reset) begin
         ack <= 1'b0;
         served <= '0;
         served_cnt <= 8'h00;
         cnt_q <= 4'h0;
      end else if (ack) begin
         ack <= 1'b0;
      end else if (ack_en && core_req.valid) begin
         if (cnt_q == wait_n) begin
            ack <= 1'b1;
            served <= core_req;
            served_cnt <= served_cnt + 8'h01;
            cnt_q <= 4'h0;
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
      end else begin
         cnt_q <= 4'h0;
      end
   end
endmodule // pic_core_model

// ### tb/test_pic_top.sv
// test_pic_top: register, priority, pin, interrupt and bypass tests.
// assumes: pic_top, pic_core_model and the bound checker are compiled.
module test_pic_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 sys_clk, reset, clk_en, reg_wr, reg_rd, bypass_ack, bypass_req, irq_status;
   logic                 model_ack, ack_en;
   logic [11:0]          reg_addr;
   logic [7:0]           reg_wdata, reg_rdata, served_cnt;
   logic [3:0]           port_pin, wait_n;
   pic_pkg::pic_src_s    src_evt;
   pic_pkg::pic_bypass_s bypass_evt;
   pic_pkg::pic_core_op_s core_op, op_tb;
   pic_pkg::pic_grant_s  core_req, served;
   int                   n_errors, n_tests;
   logic [3:0]           exp_idx [4] = '{4'h5, 4'h4, 4'h0, 4'h6};
   logic [1:0]           exp_lvl [4] = '{2'h3, 2'h2, 2'h1, 2'h1};

   // the bench may also ack on its own to provoke a stray acknowledge
   assign core_op = '{on: op_tb.on, off: op_tb.off, return_from_interrupt_op: op_tb.return_from_interrupt_op, ack: model_ack | op_tb.ack};

   pic_top pic_top_inst (.sys_clk, .reset, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .src_evt, .port_pin, .bypass_evt, .bypass_ack, .core_op, .core_req, .bypass_req, .irq_status);
   pic_core_model pic_core_model_inst (.sys_clk, .reset, .ack_en, .wait_n, .core_req, .ack(model_ack),
      .served, .served_cnt);

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   task op(input pic_pkg::pic_core_op_s v);
      @(posedge sys_clk);
      op_tb <= v;
      @(posedge sys_clk);
      op_tb <= '0;
   endtask
   task evt(input pic_pkg::pic_src_s v);
      @(posedge sys_clk);
      src_evt <= v;
      @(posedge sys_clk);
      src_evt <= '0;
   endtask
   task wait_served(input logic [7:0] n);
      int i;
      i = 0;
      while (served_cnt !== n && i < 50) begin
         @(posedge sys_clk);
         i++;
      end
      chk(served_cnt, n);
   endtask
   task tally_and_finish;
      if (n_errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // stimulus
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      #3_000_000;
      n_errors++;
      tally_and_finish();
   end
   initial begin
      {reset, clk_en, reg_wr, reg_rd, bypass_ack, ack_en} = 6'b110000;
      {reg_addr, reg_wdata, port_pin, wait_n} = '0;
      {src_evt, bypass_evt, op_tb} = '0;
      cyc(10);
      reset <= 1'b0;
      rd(pic_pkg::ADDR_REQ0, 8'h00);
      rd(pic_pkg::ADDR_REQ0_ENL, 8'h00);
      rd(pic_pkg::ADDR_CTL, 8'h00);
      rd(12'h0fd0, 8'h00);
      wr(pic_pkg::ADDR_REQ0_ENL, 8'hff);
      rd(pic_pkg::ADDR_REQ0_ENL, 8'h79);
      wr(pic_pkg::ADDR_CTL, 8'hff);
      rd(pic_pkg::ADDR_CTL, 8'h80);
      wr(pic_pkg::ADDR_CTL, 8'h00);
      rd(pic_pkg::ADDR_CTL, 8'h00);
      // polled: enable off, requests only collect
      wr(pic_pkg::ADDR_REQ0_ENL, 8'h79);
      evt(5'h1f);
      cyc(3);
      chk({7'h0, core_req.valid}, 8'h00);
      rd(pic_pkg::ADDR_REQ0, 8'h79);
      wr(pic_pkg::ADDR_REQ0, 8'h00);
      rd(pic_pkg::ADDR_REQ0, 8'h00);
      // levels: bit5 3, bit4 2, bits 6 and 0 level 1, bit3 off
      wr(pic_pkg::ADDR_REQ0_ENH, 8'h30);
      wr(pic_pkg::ADDR_REQ0_ENL, 8'h61);
      evt(5'h1f);
      ack_en <= 1'b1;
      op(4'b1000);
      for (int k = 0; k < 4; k++) begin
         wait_served(8'(k + 1));
         chk({4'h0, served.index}, {4'h0, exp_idx[k]});
         chk({6'h0, served.level}, {6'h0, exp_lvl[k]});
         if (k == 1) wait_n <= 4'h3;
         op(4'b0010);
      end
      ack_en <= 1'b0;
      cyc(4);
      chk({7'h0, core_req.valid}, 8'h00);
      rd(pic_pkg::ADDR_REQ0, 8'h08);
      wr(pic_pkg::ADDR_REQ0_ENL, 8'h08);
      cyc(3);
      chk({core_req.valid, core_req.index, 1'b0, core_req.level}, 8'h99);
      op(4'b0100);
      cyc(2);
      chk({7'h0, core_req.valid}, 8'h00);
      rd(pic_pkg::ADDR_CTL, 8'h00);
      // pins: pin0 rising, pin1 falling, pins 3:2 any edge
      wr(pic_pkg::ADDR_EDGE_SEL, 8'h02);
      port_pin <= 4'hf;
      cyc(5);
      rd(pic_pkg::ADDR_REQ1, 8'h0d);
      wr(pic_pkg::ADDR_REQ1, 8'h00);
      port_pin <= 4'h0;
      cyc(5);
      rd(pic_pkg::ADDR_REQ1, 8'h0e);
      // pin 2 at level 2 beats source three at level 1 once the gate opens
      wr(pic_pkg::ADDR_REQ1_ENH, 8'h04);
      rd(pic_pkg::ADDR_REQ1_ENH, 8'h04);
      wr(pic_pkg::ADDR_CTL, 8'h80);
      cyc(2);
      chk({core_req.valid, core_req.index, 1'b0, core_req.level}, 8'hd2);
      wr(pic_pkg::ADDR_CTL, 8'h00);
      cyc(2);
      chk({7'h0, core_req.valid}, 8'h00);
      // interrupt output: mask, unmask, clear
      chk({7'h0, irq_status}, 8'h00);
      wr(pic_pkg::ADDR_EVT_MASK, 8'h02);
      cyc(2);
      chk({7'h0, irq_status}, 8'h01);
      wr(pic_pkg::ADDR_EVT_STAT, 8'h07);
      cyc(2);
      chk({7'h0, irq_status}, 8'h00);
      rd(pic_pkg::ADDR_EVT_STAT, 8'h00);
      // an ack with nothing offered is flagged as stray
      op(4'b0001);
      wr(pic_pkg::ADDR_EVT_MASK, 8'h04);
      rd(pic_pkg::ADDR_EVT_STAT, 8'h04);
      chk({7'h0, irq_status}, 8'h01);
      // bypass traps ignore the enables
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk);
         bypass_evt <= 3'(1 << i);
         @(posedge sys_clk);
         bypass_evt <= '0;
         cyc(3);
         chk({7'h0, bypass_req}, 8'h01);
         bypass_ack <= 1'b1;
         @(posedge sys_clk);
         bypass_ack <= 1'b0;
         cyc(1);
         chk({7'h0, bypass_req}, 8'h00);
      end
      // a second reset in mid-run returns pending requests to zero
      reset <= 1'b1;
      cyc(2);
      reset <= 1'b0;
      rd(pic_pkg::ADDR_REQ0, 8'h00);
      chk({7'h0, irq_status}, 8'h00);
      rd(pic_pkg::ADDR_CTL, 8'h00);
      tally_and_finish();
   end
endmodule // test_pic_top
